// ===== rtl/main_clock_select.v
// Function
// RULE_01: main mode register resets to zero
// RULE_02: periph select picks periph and cpu source
// RULE_03: status bit shows actual cpu source
// RULE_04: status bit read-only, writes ignored
// RULE_05: periph select bit changes only once
// RULE_06: watchdog always on low-speed oscillator
// RULE_07: status cleared on reset, stop, x1 stop
// RULE_08: status bits set in thermometer order
// RULE_09: status register read-only, byte readable
// RULE_10: counting stops at selected length; code counts to 2^16 until the first stop or x1 stop
// RULE_11: three-bit code selects wait length
// RULE_12: select register resets to 05H
// RULE_13: hold cpu until wait elapsed
// RULE_14: software polls status on internal clock
// RULE_15: software programs select before stop
// RULE_16: no select writes during wait
// RULE_17: select length covers polled time
// RULE_18: count begins only once x1 oscillates
// RULE_19: select register byte writes only
// RULE_20: mode register bit and byte writes
// RULE_21: trim resets to 10H, byte writes
// RULE_22: x1 stop bit stops oscillator
// RULE_23: trim code monotonic to frequency
// RULE_24: counter restarts when status cleared
`timescale 1ns/100ps
`default_nettype none
`include "clk_sel_consts.vh"
module main_clock_select #(
    parameter CNT_W = `CNT_W
) (
    input  wire                 i_clk,
    input  wire                 i_rst,
    input  wire [`ADDR_W-1:0]   i_addr,
    input  wire [7:0]           i_wdata,
    input  wire                 i_wr,
    input  wire                 i_rd,
    input  wire                 i_stop_exec,
    input  wire                 i_stop_release,
    input  wire                 i_x1_osc_running,
    output reg  [7:0]           o_rdata,
    output reg                  o_periph_clock_source_sel,
    output reg                  o_cpu_clock_source_status,
    output reg                  o_x1_osc_stop,
    output reg  [4:0]           o_internal_osc_trim,
    output reg                  o_cpu_hold,
    output wire                 o_wdt_clk_sel_ls
);

    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;

    function [CNT_W-1:0] code_len;
        input [2:0] code;
        begin
            case (code) // RULE_11
                3'h1:    code_len = `CNT_2P11;
                3'h2:    code_len = `CNT_2P13;
                3'h3:    code_len = `CNT_2P14;
                3'h4:    code_len = `CNT_2P15;
                default: code_len = `CNT_2P16;
            endcase
        end
    endfunction

    reg                 cpu_sel_r;
    reg                 periph_locked_r;
    reg  [2:0]          stab_code_r;
    reg  [CNT_W-1:0]    cnt_r;
    reg  [4:0]          stab_flags_r;
    reg  [1:0]          state_r;
    reg  [1:0]          state_nxt;
    reg                 run_sync1_r;
    reg                 run_sync2_r;
    reg                 limit_r;
    wire [CNT_W-1:0]    sel_len;
    wire                clr_status;
    wire                wr_mode;
    wire [7:0]          mode_rd;

    assign sel_len    = code_len(stab_code_r);
    assign clr_status = i_stop_exec | o_x1_osc_stop; // RULE_07
    assign wr_mode    = i_wr && (i_addr == `OFS_MAIN_MODE);
    assign o_wdt_clk_sel_ls = 1'b1; // RULE_06
    assign mode_rd = {5'h00, periph_locked_r & o_periph_clock_source_sel,
                      o_cpu_clock_source_status, cpu_sel_r};

    // oscillator-running level comes from the analog side
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run_sync1_r <= 1'b0;
            run_sync2_r <= 1'b0;
        end else begin
            run_sync1_r <= i_x1_osc_running;
            run_sync2_r <= run_sync1_r;
        end
    end

    // mode register; bit 1 is status and not writable
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cpu_sel_r                 <= `RST_CPU_SEL; // RULE_01
            o_periph_clock_source_sel <= `RST_PERIPH_SEL;
            periph_locked_r           <= 1'b0;
            o_cpu_clock_source_status <= 1'b0;
        end else begin
            if (wr_mode) begin // RULE_20 RULE_04
                cpu_sel_r <= i_wdata[`BIT_CPU_SEL];
                if (!periph_locked_r &&
                    i_wdata[`BIT_PERIPH_SEL] != o_periph_clock_source_sel) begin // RULE_05
                    o_periph_clock_source_sel <= i_wdata[`BIT_PERIPH_SEL];
                    periph_locked_r           <= 1'b1;
                end
            end
            o_cpu_clock_source_status <= o_periph_clock_source_sel & cpu_sel_r; // RULE_02 RULE_03
        end
    end

    // select, stop and trim registers, byte access only
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stab_code_r         <= `RST_STAB_SELECT; // RULE_12
            o_x1_osc_stop       <= `RST_OSC_STOP;
            o_internal_osc_trim <= `RST_TRIM; // RULE_21
        end else if (i_wr) begin
            if (i_addr == `OFS_STAB_SELECT)
                stab_code_r <= i_wdata[2:0]; // RULE_19
            if (i_addr == `OFS_OSC_STOP)
                o_x1_osc_stop <= i_wdata[`BIT_X1_STOP]; // RULE_22
            if (i_addr == `OFS_TRIM)
                o_internal_osc_trim <= i_wdata[4:0]; // RULE_21 RULE_23
        end
    end

    // stabilization counter
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r        <= {CNT_W{1'b0}};
            stab_flags_r <= 5'h00; // RULE_07
            limit_r      <= 1'b0;
        end else if (clr_status) begin
            cnt_r        <= {CNT_W{1'b0}}; // RULE_24
            stab_flags_r <= 5'h00;
            limit_r      <= 1'b1;
        end else begin
            if (run_sync2_r && (limit_r ? (cnt_r < sel_len) : (cnt_r < `CNT_2P16))) // RULE_18 RULE_10
                cnt_r <= cnt_r + 1'b1;
            if (cnt_r >= `CNT_2P11) stab_flags_r[4] <= 1'b1; // RULE_08
            if (cnt_r >= `CNT_2P13) stab_flags_r[3] <= 1'b1;
            if (cnt_r >= `CNT_2P14) stab_flags_r[2] <= 1'b1;
            if (cnt_r >= `CNT_2P15) stab_flags_r[1] <= 1'b1;
            if (cnt_r >= `CNT_2P16) stab_flags_r[0] <= 1'b1;
        end
    end

    // cpu hold after stop release when running on x1
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (i_stop_release && o_cpu_clock_source_status)
                state_nxt = ST_WAIT;
            ST_WAIT: if (cnt_r >= sel_len)
                state_nxt = ST_IDLE; // RULE_13
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r    <= ST_IDLE;
            o_cpu_hold <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            o_cpu_hold <= (state_nxt == ST_WAIT); // RULE_13
        end
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            case (i_addr)
                `OFS_STAB_STATUS: o_rdata <= {3'h0, stab_flags_r}; // RULE_09
                `OFS_STAB_SELECT: o_rdata <= {5'h00, stab_code_r};
                `OFS_MAIN_MODE:   o_rdata <= mode_rd;
                `OFS_OSC_STOP:    o_rdata <= {o_x1_osc_stop, 7'h00};
                `OFS_TRIM:        o_rdata <= {3'h0, o_internal_osc_trim};
                default:          o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule // main_clock_select
`default_nettype wire

// ===== rtl/clk_sel_consts.vh
`ifndef CLK_SEL_CONSTS_VH
`define CLK_SEL_CONSTS_VH
`define ADDR_W            16
`define OFS_STAB_STATUS   16'hFFA3
`define OFS_STAB_SELECT   16'hFFA4
`define OFS_MAIN_MODE     16'hFFA5
`define OFS_OSC_STOP      16'hFFA2
`define OFS_TRIM          16'hFF30
`define RST_MAIN_MODE     8'h00
`define RST_CPU_SEL       1'h0
`define RST_PERIPH_SEL    1'h0
`define RST_STAB_SELECT   3'h5
`define RST_TRIM          5'h10
`define RST_OSC_STOP      1'h0
`define BIT_CPU_SEL       0
`define BIT_CPU_STATUS    1
`define BIT_PERIPH_SEL    2
`define BIT_X1_STOP       7
`define CNT_2P11          17'h00800
`define CNT_2P13          17'h02000
`define CNT_2P14          17'h04000
`define CNT_2P15          17'h08000
`define CNT_2P16          17'h10000
`define CNT_W             17
`endif

// ===== testbench/main_clock_select_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "clk_sel_consts.vh"
module main_clock_select_chk #(parameter CNT_W = `CNT_W) (
    input wire logic i_clk, i_rst, i_wr, i_rd, i_stop_exec, i_stop_release, i_x1_osc_running,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata, o_rdata,
    input wire logic o_periph_clock_source_sel, o_cpu_clock_source_status, o_x1_osc_stop, o_cpu_hold,
    input wire logic o_wdt_clk_sel_ls,
    input wire logic [4:0] o_internal_osc_trim
);
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
sequence s_stat_rd; i_rd && i_addr == `OFS_STAB_STATUS; endsequence
sequence s_mode_wr; i_wr && i_addr == `OFS_MAIN_MODE; endsequence
AST_WDT: assert property (o_wdt_clk_sel_ls) else $error("wdt clock");
AST_MODE_RST: assert property ($fell(i_rst) |-> !o_periph_clock_source_sel && !o_cpu_clock_source_status)
    else $error("mode reset");
AST_SRC: assert property (o_cpu_clock_source_status |-> o_periph_clock_source_sel) else $error("src");
AST_ONCE: assert property (!$fell(o_periph_clock_source_sel)) else $error("psel fell");
AST_PSET: assert property (s_mode_wr ##0 (i_wdata[2] && !o_periph_clock_source_sel) |=> o_periph_clock_source_sel)
    else $error("psel set");
AST_THERM: assert property (s_stat_rd |=> o_rdata inside {8'h00, 8'h10, 8'h18, 8'h1C, 8'h1E, 8'h1F})
    else $error("status shape");
AST_CLR: assert property (s_stat_rd ##0 (o_x1_osc_stop && $past(o_x1_osc_stop)) |=> o_rdata == 8'h00)
    else $error("status clear");
AST_IDLE: assert property (!i_rd |=> o_rdata == 8'h00) else $error("rdata idle");
AST_HOLD: assert property ($rose(o_cpu_hold) |-> $past(i_stop_release) && o_cpu_clock_source_status)
    else $error("hold");
AST_TRIM: assert property ($fell(i_rst) |-> o_internal_osc_trim == 5'h10) else $error("trim");
AST_STOP: assert property (i_wr && i_addr == `OFS_OSC_STOP |=> o_x1_osc_stop == $past(i_wdata[7]))
    else $error("x1 stop");
endmodule // main_clock_select_chk
bind main_clock_select main_clock_select_chk #(.CNT_W(CNT_W)) u_chk (.*);
`default_nettype wire

// ===== testbench/main_clock_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "clk_sel_consts.vh"
module main_clock_select_tb;
logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_stop_exec = 0, i_stop_release = 0, i_x1_osc_running = 0;
logic [15:0] i_addr = 0;
logic [7:0] i_wdata = 0, o_rdata, d;
logic o_periph_clock_source_sel, o_cpu_clock_source_status, o_x1_osc_stop, o_cpu_hold, o_wdt_clk_sel_ls;
logic [4:0] o_internal_osc_trim;
integer num_errors = 0, num_checks = 0, seed = 32'h585fa15f, i, t = 0, t0;
always #20 i_clk = ~i_clk;
always @(posedge i_clk) t <= t + 1;
main_clock_select dut (.*);
function automatic integer th(input integer k); return k == 0 ? 2048 : 1 << (12 + k); endfunction
function automatic integer fl(input integer k); return (31 << (5 - k)) & 31; endfunction
task automatic chk(input logic [7:0] s, e, input string nm);
    num_checks++;
    if (s !== e) begin
        num_errors++;
        $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
endtask
task automatic wr(input logic [15:0] a, input logic [7:0] v);
    i_addr <= a; i_wdata <= v; i_wr <= 1; @(posedge i_clk); i_wr <= 0; @(posedge i_clk);
endtask
task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    i_addr <= a; i_rd <= 1; @(posedge i_clk); i_rd <= 0; #1 chk(o_rdata, e, nm); @(posedge i_clk);
endtask
task automatic upto(input integer n); while (t - t0 < n) @(posedge i_clk); endtask
task automatic conclude;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 0; @(posedge i_clk);
    chk(o_internal_osc_trim, 8'h10, "trim");
    rd(`OFS_MAIN_MODE, 8'h00, "mode");
    rd(`OFS_STAB_SELECT, 8'h05, "select");
    rd(16'hFFF0, 8'h00, "unmapped");
    $display("reset test done");
    wr(`OFS_MAIN_MODE, 8'h02); rd(`OFS_MAIN_MODE, 8'h00, "mode ro");
    wr(`OFS_MAIN_MODE, 8'h05); rd(`OFS_MAIN_MODE, 8'h07, "mode x1");
    chk(o_cpu_clock_source_status, 1, "cpu status");
    wr(`OFS_MAIN_MODE, 8'h00); rd(`OFS_MAIN_MODE, 8'h04, "mode once");
    chk(o_periph_clock_source_sel, 1, "psel kept");
    for (i = 0; i < 4; i++) begin
        d = 8'($random(seed)); wr(`OFS_TRIM, d);
        chk(o_internal_osc_trim, d[4:0], "trim wr");
    end
    $display("mode test done");
    t0 = t; upto(3000); rd(`OFS_STAB_STATUS, 8'h00, "no osc");
    i_x1_osc_running <= 1; t0 = t;
    for (i = 0; i < 5; i++) begin
        upto(th(i) - 16); rd(`OFS_STAB_STATUS, 8'(fl(i)), "before");
        upto(th(i) + 16); rd(`OFS_STAB_STATUS, 8'(fl(i + 1)), "after");
    end
    $display("count test done");
    wr(`OFS_MAIN_MODE, 8'h01); wr(`OFS_STAB_SELECT, 8'h01);
    i_stop_exec <= 1; @(posedge i_clk); t0 = t;
    i_stop_exec <= 0; i_stop_release <= 1; @(posedge i_clk);
    i_stop_release <= 0; @(posedge i_clk); @(posedge i_clk);
    chk(o_cpu_hold, 1, "hold");
    rd(`OFS_STAB_STATUS, 8'h00, "stop clr");
    upto(2048 + 16); chk(o_cpu_hold, 0, "hold end");
    upto(8192 + 16); rd(`OFS_STAB_STATUS, 8'h10, "limit");
    wr(`OFS_OSC_STOP, 8'h80); i_x1_osc_running <= 0;
    chk(o_x1_osc_stop, 1, "x1 stop");
    rd(`OFS_STAB_STATUS, 8'h00, "x1 clr");
    wr(`OFS_OSC_STOP, 8'h00);
    i_x1_osc_running <= 1;
    wr(`OFS_MAIN_MODE, 8'h00);
    i_stop_exec <= 1;
    @(posedge i_clk);
    i_stop_exec <= 0;
    i_stop_release <= 1;
    @(posedge i_clk);
    i_stop_release <= 0;
    @(posedge i_clk);
    @(posedge i_clk);
    chk(o_cpu_hold, 0, "no hold internal");
    d = 0;
    // software poll on the internal clock, bounded
    for (i = 0; i < 2000 && d != 8'h10; i++) begin
        i_addr <= `OFS_STAB_STATUS;
        i_rd <= 1;
        @(posedge i_clk);
        i_rd <= 0;
        #1 d = o_rdata;
        @(posedge i_clk);
    end
    chk(d, 8'h10, "poll");
    $display("stop test done");
    conclude();
end
endmodule // main_clock_select_tb
`default_nettype wire
